// >>> verilog/bmps_burst_sequencer.sv
`include "bmps_map.svh"

module bmps_burst_sequencer
	import bmps_pkg::*;
#(
	parameter int PERIOD_W = 18,
	parameter int BURST_PERIOD_CYC = `BMPS_BURST_PERIOD_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Feedback pin comparators
	input wire logic ctrlBelowEntry,
	input wire logic ctrlOptoAboveTarget,
	input wire logic ctrlOptoBelowLow,
	input wire logic ctrlAboveStop,
	input wire logic ctrlBelowPullDownLimit,
	// Energy request from the feedback loop
	input wire logic burstRequest,
	// Protection state
	input wire logic protActive,
	// Driver and mode
	output logic driverPulse,
	output logic burstMode,
	output logic lowPowerIdle,
	output bmps_count_t pulseCount,
	// Feedback pin control
	output logic ctrlClampEn,
	output logic ctrlPullDown,
	output bmps_bias_t biasCode,
	// Supply pin
	output logic supplyFastDischargeSink
);
	localparam int TW = `BMPS_TIMER_W;
	localparam int PRW = PERIOD_W + 7;

	if (PERIOD_W < 8 || PERIOD_W > 24) begin : gPeriodWidthCheck
		$error("bmps_burst_sequencer: PERIOD_W out of range");
	end
	if (BURST_PERIOD_CYC < 2 || BURST_PERIOD_CYC >= (1 << PERIOD_W)) begin : gPeriodCheck
		$error("bmps_burst_sequencer: BURST_PERIOD_CYC does not fit PERIOD_W");
	end
	if (`BMPS_SPACING_CYC >= (1 << TW) || `BMPS_PD_CYC >= (1 << TW)) begin : gTimerCheck
		$error("bmps_burst_sequencer: timer width too small");
	end
	if (`BMPS_SPACING_CYC < 2 || `BMPS_PD_CYC < 2) begin : gTimerMinCheck
		$error("bmps_burst_sequencer: spacing and pull-down need two cycles at least");
	end
	// Bias rates load the same narrow timers
	if (`BMPS_BIAS_SLOW_CYC < 2 || `BMPS_BIAS_SLOW_CYC >= (1 << TW)) begin : gSlowRateCheck
		$error("bmps_burst_sequencer: slow bias rate does not fit the timer");
	end
	if (`BMPS_BIAS_FAST_CYC < 2 || `BMPS_BIAS_FAST_CYC >= (1 << TW)) begin : gFastRateCheck
		$error("bmps_burst_sequencer: fast bias rate does not fit the timer");
	end
	// Limits must leave at least one legal count
	if (`BMPS_MIN_PULSES < 1 || `BMPS_MIN_PULSES > `BMPS_MAX_PULSES) begin : gPulseLimitCheck
		$error("bmps_burst_sequencer: pulse count limits out of order");
	end
	// Shortest burst must fit inside the target period
	if (BURST_PERIOD_CYC <= `BMPS_MIN_PULSES * `BMPS_SPACING_CYC) begin : gPeriodRoomCheck
		$error("bmps_burst_sequencer: target period shorter than the shortest burst");
	end

	bmps_state_e state_q;
	bmps_state_e state_d;
	bmps_count_t cur_q;
	bmps_count_t cur_d;
	bmps_count_t left_q;
	bmps_count_t left_d;
	logic [PERIOD_W-1:0] meas_q;
	logic startBurst;
	logic pulseNow;
	logic loadSpace;
	logic loadPd;
	logic spaceExp;
	logic pdExp;
	logic stepExp;
	logic stepFast;
	logic stepFast_q;
	logic loadStep;
	logic [TW-1:0] stepValue;
	logic [6:0] twoCur;
	logic [PRW-1:0] tgtProd;
	logic [PRW-1:0] upProd;
	logic [PRW-1:0] dnProd;
	logic addPulse;
	logic removePulse;

	// Pulse spacing timer
	// Loaded one short, as the reload lands on the edge after expiry
	bmps_timer #(
		.W(TW)
	) uSpaceTimer (
		.clock(clock),
		.rst(rst),
		.load(loadSpace),
		.loadValue(TW'(`BMPS_SPACING_CYC - 1)),
		.expired(spaceExp)
	);

	// Feedback pull-down timer
	bmps_timer #(
		.W(TW)
	) uPdTimer (
		.clock(clock),
		.rst(rst),
		.load(loadPd),
		.loadValue(TW'(`BMPS_PD_CYC - 1)),
		.expired(pdExp)
	);

	// Bias step rate timer
	bmps_timer #(
		.W(TW)
	) uStepTimer (
		.clock(clock),
		.rst(rst),
		.load(loadStep),
		.loadValue(stepValue),
		.expired(stepExp)
	);

	// Half-pulse decision: compare 2n*Ttarget against (2n+-1)*Tmeasured
	assign twoCur = {1'b0, cur_q} << 1; // R12
	assign tgtProd = PRW'(twoCur) * PRW'(BURST_PERIOD_CYC); // R6
	assign upProd = PRW'(twoCur + 7'h01) * PRW'(meas_q); // R12
	assign dnProd = PRW'(twoCur - 7'h01) * PRW'(meas_q); // R12
	// Allowed deviation is one part in 2n, so it narrows as n grows
	assign addPulse = (tgtProd > upProd); // R13
	assign removePulse = (tgtProd < dnProd); // R13

	always_comb begin
		state_d = state_q;
		cur_d = cur_q;
		left_d = left_q;
		startBurst = 1'b0;
		pulseNow = 1'b0;
		loadSpace = 1'b0;
		loadPd = 1'b0;
		case (state_q)
			ST_NORMAL: begin
				if (ctrlBelowEntry && !protActive) begin // R1
					cur_d = `BMPS_MIN_PULSES; // R8
					startBurst = 1'b1;
				end
			end
			ST_RUN: begin
				if (ctrlAboveStop) begin // R15
					state_d = ctrlBelowPullDownLimit ? ST_WAIT : ST_PULLDOWN; // R16
					loadPd = !ctrlBelowPullDownLimit; // R16
				end else if (spaceExp) begin // R5
					if (left_q == 6'h00) begin
						state_d = ctrlBelowPullDownLimit ? ST_WAIT : ST_PULLDOWN; // R16
						loadPd = !ctrlBelowPullDownLimit; // R16
					end else begin
						pulseNow = 1'b1;
						left_d = left_q - 6'h01;
						loadSpace = 1'b1;
					end
				end
			end
			ST_PULLDOWN: begin
				if (pdExp) begin // R16
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// A request ends the idle gap at once, however short the period
				if (burstRequest) begin // R11
					if (addPulse && cur_q == `BMPS_MAX_PULSES) begin // R14
						state_d = ST_NORMAL;
					end else if (addPulse) begin // R7
						cur_d = cur_q + 6'h01;
						startBurst = 1'b1;
					end else if (removePulse && cur_q > `BMPS_MIN_PULSES) begin // R8
						cur_d = cur_q - 6'h01;
						startBurst = 1'b1;
					end else begin
						// Late request at minimum count simply stretches the period
						startBurst = 1'b1; // R9
					end
				end
			end
			default: begin
				state_d = ST_NORMAL;
			end
		endcase
		if (startBurst) begin
			state_d = ST_RUN;
			pulseNow = 1'b1;
			left_d = cur_d - 6'h01;
			loadSpace = 1'b1; // R18
		end
		// Protection stops switching whatever the burst engine was doing
		if (protActive) begin
			state_d = ST_NORMAL;
			startBurst = 1'b0;
			pulseNow = 1'b0;
		end
	end

	// Burst engine state
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= ST_NORMAL;
		end else begin
			state_q <= state_d;
		end
	end

	// Pulses per burst; entry from normal mode starts again at the minimum
	always_ff @(posedge clock) begin
		if (rst) begin
			cur_q <= `BMPS_MIN_PULSES;
		end else begin
			cur_q <= cur_d;
		end
	end

	// Pulses still to issue in the running burst
	always_ff @(posedge clock) begin
		if (rst) begin
			left_q <= 6'h00;
		end else begin
			left_q <= left_d;
		end
	end

	// Burst period measured from one burst start to the next, saturating
	always_ff @(posedge clock) begin
		if (rst) begin
			meas_q <= '0;
		end else if (startBurst) begin
			// Starts at one so the value spans a full start-to-start period
			meas_q <= {{(PERIOD_W-1){1'b0}}, 1'b1}; // R18
		end else if (state_q == ST_NORMAL) begin
			meas_q <= '0; // R18
		end else if (meas_q != '1) begin
			meas_q <= meas_q + {{(PERIOD_W-1){1'b0}}, 1'b1}; // R18
		end
	end

	// Registered outputs, aligned with the state they describe
	always_ff @(posedge clock) begin
		if (rst) begin
			driverPulse <= 1'b0;
			burstMode <= 1'b0;
			lowPowerIdle <= 1'b0;
			ctrlClampEn <= 1'b0;
			ctrlPullDown <= 1'b0;
			pulseCount <= `BMPS_MIN_PULSES;
		end else begin
			driverPulse <= pulseNow; // R5
			burstMode <= (state_d != ST_NORMAL); // R1
			lowPowerIdle <= (state_d == ST_WAIT); // R10
			ctrlClampEn <= (state_d == ST_RUN); // R15
			ctrlPullDown <= (state_d == ST_PULLDOWN); // R16
			pulseCount <= cur_d; // R7
		end
	end

	// Bias step rate: fast when optocurrent is low in burst, slow otherwise
	assign stepFast = (state_q != ST_NORMAL) && ctrlOptoBelowLow; // R3
	assign stepValue = stepFast ? TW'(`BMPS_BIAS_FAST_CYC - 1) // R3
		: TW'(`BMPS_BIAS_SLOW_CYC - 1);
	// Reload on a rise of the fast condition so the faster rate takes hold at once
	assign loadStep = stepExp || (stepFast && !stepFast_q); // R3

	always_ff @(posedge clock) begin
		if (rst) begin
			stepFast_q <= 1'b0;
		end else begin
			stepFast_q <= stepFast;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			biasCode <= `BMPS_BIAS_NOMINAL;
		end else if (stepExp) begin
			if (state_q == ST_NORMAL) begin
				if (biasCode != `BMPS_BIAS_NOMINAL) begin
					biasCode <= biasCode + 8'h01; // R4
				end
			end else if (ctrlOptoBelowLow || !ctrlOptoAboveTarget) begin
				if (biasCode != `BMPS_BIAS_NOMINAL) begin
					biasCode <= biasCode + 8'h01; // R2
				end
			end else if (biasCode != 8'h00) begin
				biasCode <= biasCode - 8'h01; // R2
			end
		end
	end

	// Sink stays on until the supply collapses and resets the device
	always_ff @(posedge clock) begin
		if (rst) begin
			supplyFastDischargeSink <= 1'b0;
		end else if (protActive) begin
			supplyFastDischargeSink <= 1'b1; // R17
		end
	end
endmodule

// >>> inc/bmps_map.svh
`ifndef BMPS_MAP_SVH
`define BMPS_MAP_SVH
// Contract
// R1: Enter burst mode from normal when feedback pin falls below entry threshold.
// R2: In burst, steer bias down until optocurrent settles at its target.
// R3: Optocurrent below low threshold raises the bias at the fast rate.
// R4: Back in normal mode, ramp bias slowly up to nominal.
// R5: Pulses inside a burst are never spaced wider than the minimum frequency period.
// R6: Bursts aim to repeat at the target burst period.
// R7: Pulse count per burst follows requested power, more at higher load.
// R8: A burst never carries fewer than the minimum pulse count; the stop of R15 still ends a burst after fewer pulses.
// R9: Too much power at minimum count stretches the burst period beyond target.
// R10: Between bursts the circuits sit in a low-consumption state.
// R11: A load rise starts the next burst at once, then pulses are added.
// R12: Count changes by one only when new count differs by half a pulse.
// R13: Allowed period deviation before a count change shrinks with larger counts.
// R14: A count beyond the upper limit returns the device to normal mode.
// R15: Feedback pin clamped during burst; stop current ends the burst immediately.
// R16: After each burst pull feedback pin low, unless its current is low.
// R17: Entering latched protection or safe restart enables the supply discharge sink.
// R18: Pulse spacing, burst period and pull-down time come from clock cycle counters.

// Clock
`define BMPS_CLK_MHZ 100
`define BMPS_CLK_PERIOD_NS 10

// Minimum switching frequency inside a burst, longest spacing rounds down
`define BMPS_MIN_FSW_KHZ 25
`define BMPS_SPACING_CYC ((`BMPS_CLK_MHZ * 1000) / `BMPS_MIN_FSW_KHZ)

// Target burst period
`define BMPS_BURST_PERIOD_US 1250
`define BMPS_BURST_PERIOD_CYC (`BMPS_BURST_PERIOD_US * `BMPS_CLK_MHZ)

// Feedback pull-down after a burst, least time rounds up
`define BMPS_PD_TIME_NS 12500
`define BMPS_PD_CYC ((`BMPS_PD_TIME_NS + `BMPS_CLK_PERIOD_NS - 1) / `BMPS_CLK_PERIOD_NS)

// Pulse count limits and reset value
`define BMPS_MIN_PULSES 6'h03
`define BMPS_MAX_PULSES 6'h28

// Bias code, nominal is the top code
`define BMPS_BIAS_NOMINAL 8'hff
`define BMPS_BIAS_SLOW_CYC 2000
`define BMPS_BIAS_FAST_CYC 200

// Timer width shared by the short counters
`define BMPS_TIMER_W 12

`endif

// >>> inc/bmps_pkg.sv
package bmps_pkg;
	typedef enum logic [1:0] {ST_NORMAL, ST_RUN, ST_PULLDOWN, ST_WAIT} bmps_state_e;
	typedef logic [7:0] bmps_bias_t;
	typedef logic [5:0] bmps_count_t;
endpackage

// >>> verilog/bmps_timer.sv
module bmps_timer #(
	parameter int W = 12
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Control
	input wire logic load,
	input wire logic [W-1:0] loadValue,
	// Status
	output logic expired
);
	logic [W-1:0] count_q;

	if (W < 2) begin : gWidthCheck
		$error("bmps_timer: W must be at least 2");
	end

	// Expiry shows N edges after loading N; a reload on expiry repeats every N+1
	always_ff @(posedge clock) begin
		if (rst) begin
			count_q <= '0;
		end else if (load) begin
			count_q <= loadValue;
		end else if (count_q != '0) begin
			count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign expired = (count_q == '0);
endmodule

// >>> verif/bmps_burst_sequencer_checker.sv
module bmps_burst_sequencer_checker
	import bmps_pkg::*;
#(
	parameter int PERIOD_W = 18,
	parameter int BURST_PERIOD_CYC = 125000
) (
	// Clock and reset
	input logic clock,
	input logic rst,
	// Inputs
	input logic ctrlBelowEntry,
	input logic ctrlOptoAboveTarget,
	input logic ctrlOptoBelowLow,
	input logic ctrlAboveStop,
	input logic ctrlBelowPullDownLimit,
	input logic burstRequest,
	input logic protActive,
	// Outputs
	input logic driverPulse,
	input logic burstMode,
	input logic lowPowerIdle,
	input bmps_count_t pulseCount,
	input logic ctrlClampEn,
	input logic ctrlPullDown,
	input bmps_bias_t biasCode,
	input logic supplyFastDischargeSink
);
	// Length of the running pull-down
	logic [11:0] pdCnt_q;
	always_ff @(posedge clock) begin
		pdCnt_q <= ctrlPullDown ? pdCnt_q + 12'h001 : 12'h000;
	end
	// Cycles since the last gate pulse while a burst runs
	logic [12:0] gapCnt_q;
	always_ff @(posedge clock) begin
		if (rst || !ctrlClampEn) begin
			gapCnt_q <= 13'h0000;
		end else if (driverPulse) begin
			gapCnt_q <= 13'h0001;
		end else if (gapCnt_q != 13'h1fff) begin
			gapCnt_q <= gapCnt_q + 13'h0001;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_entry;
		!burstMode && ctrlBelowEntry && !protActive |=> driverPulse && burstMode && ctrlClampEn;
	endproperty
	a_entry: assert property (p_entry) else $error("no entry");
	property p_spacing;
		ctrlClampEn && !driverPulse |-> gapCnt_q < 13'h0fa0;
	endproperty
	a_spacing: assert property (p_spacing) else $error("spacing");
	property p_count;
		pulseCount >= 6'h03 && pulseCount <= 6'h28;
	endproperty
	a_count: assert property (p_count) else $error("count range");
	property p_idle;
		lowPowerIdle |-> burstMode && !driverPulse && !ctrlClampEn && !ctrlPullDown;
	endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_request;
		lowPowerIdle && burstRequest && !protActive |=> driverPulse || !burstMode;
	endproperty
	a_request: assert property (p_request) else $error("request");
	property p_stop;
		ctrlClampEn && ctrlAboveStop && !protActive |=> !driverPulse ##1 !driverPulse && !ctrlClampEn;
	endproperty
	a_stop: assert property (p_stop) else $error("stop");
	property p_pdLen;
		$fell(ctrlPullDown) && !$past(protActive) |-> pdCnt_q == 12'h4e2;
	endproperty
	a_pdLen: assert property (p_pdLen) else $error("pull-down length");
	property p_sink;
		protActive |=> supplyFastDischargeSink && !burstMode && !driverPulse;
	endproperty
	a_sink: assert property (p_sink) else $error("sink");
	property p_hold;
		supplyFastDischargeSink |=> supplyFastDischargeSink;
	endproperty
	a_hold: assert property (p_hold) else $error("sink hold");
	property p_bias;
		!burstMode && !$past(burstMode) |-> biasCode >= $past(biasCode);
	endproperty
	a_bias: assert property (p_bias) else $error("bias fell");
endmodule

bind bmps_burst_sequencer bmps_burst_sequencer_checker #(.PERIOD_W(PERIOD_W),
	.BURST_PERIOD_CYC(BURST_PERIOD_CYC)) i_checker (.clock, .rst, .ctrlBelowEntry,
	.ctrlOptoAboveTarget, .ctrlOptoBelowLow, .ctrlAboveStop, .ctrlBelowPullDownLimit,
	.burstRequest, .protActive, .driverPulse, .burstMode, .lowPowerIdle, .pulseCount,
	.ctrlClampEn, .ctrlPullDown, .biasCode, .supplyFastDischargeSink);

// >>> verif/bmps_plant.sv
module bmps_plant (
	// Gate and clamp
	input wire logic clock,
	input wire logic driverPulse,
	input wire logic ctrlClampEn,
	// Finished burst
	output logic burstDone,
	output logic [7:0] burstPulses
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt = 8'h00;
	logic clampQ = 1'b0;
	// Gate pulses counted per clamp window
	always @(posedge clock) begin
		clampQ <= ctrlClampEn;
		burstDone <= clampQ && !ctrlClampEn;
		if (clampQ && !ctrlClampEn) begin
			burstPulses <= cnt;
			cnt <= 8'h00;
		end else if (driverPulse === 1'b1) begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

// >>> verif/bmps_burst_sequencer_test.sv
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin errCount++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module bmps_burst_sequencer_test
	import bmps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Short period keeps the run small
	localparam int BPC = 20000;
	logic clock = 1'b0, rst = 1'b1, ctrlBelowEntry = 1'b0, ctrlOptoAboveTarget = 1'b1;
	logic ctrlOptoBelowLow = 1'b0, ctrlAboveStop = 1'b0, ctrlBelowPullDownLimit = 1'b0;
	logic burstRequest = 1'b0, protActive = 1'b0;
	logic driverPulse, burstMode, lowPowerIdle, ctrlClampEn, ctrlPullDown;
	logic supplyFastDischargeSink, burstDone;
	logic [7:0] burstPulses;
	bmps_count_t pulseCount, n;
	bmps_bias_t biasCode, b;
	bmps_count_t expQ[$];
	int errCount = 0, nCompared = 0, cyc = 0, lastStart, i;
	logic [31:0] seed = 32'h633477fb;
	bmps_burst_sequencer #(.BURST_PERIOD_CYC(BPC)) i_dut (.clock, .rst, .ctrlBelowEntry,
		.ctrlOptoAboveTarget, .ctrlOptoBelowLow, .ctrlAboveStop, .ctrlBelowPullDownLimit,
		.burstRequest, .protActive, .driverPulse, .burstMode, .lowPowerIdle, .pulseCount,
		.ctrlClampEn, .ctrlPullDown, .biasCode, .supplyFastDischargeSink);
	bmps_plant i_plant (.clock, .driverPulse, .ctrlClampEn, .burstDone, .burstPulses);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic completeRun();
		$display("Compared %0d, mismatches %0d", nCompared, errCount);
		if (errCount == 0 && nCompared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic waitIdle();
		int w = 0;
		while (lowPowerIdle !== 1'b1 && w < 30000) begin
			@(posedge clock);
			#1;
			w++;
		end
		`CHK(lowPowerIdle, 1'b1)
	endtask
	// Request after a gap; expected count follows the half-pulse margin
	task automatic burst(input int gap, input logic stop);
		longint t;
		repeat (gap + 1) @(posedge clock);
		burstRequest <= 1'b1;
		@(posedge clock);
		burstRequest <= 1'b0;
		t = cyc - lastStart;
		lastStart = cyc;
		if (2 * n * BPC > (2 * n + 1) * t) n++;
		else if (2 * n * BPC < (2 * n - 1) * t && n > 6'h03) n--;
		expQ.push_back(stop ? 6'h01 : n);
		#1;
		`CHK(pulseCount, n)
		if (stop) begin
			@(posedge clock);
			ctrlAboveStop <= 1'b1;
			ctrlBelowPullDownLimit <= 1'b1;
			@(posedge clock);
			ctrlAboveStop <= 1'b0;
			repeat (4) @(posedge clock);
			#1;
			`CHK(lowPowerIdle, 1'b1)
		end
		waitIdle();
	endtask
	initial begin
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			errCount++;
			completeRun();
		end
	end
	// Watcher takes the oldest note per finished burst
	always @(negedge clock) begin
		if (burstDone === 1'b1 && expQ.size() > 0) begin
			`CHK(burstPulses, {2'b00, expQ[0]})
			void'(expQ.pop_front());
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		n = 6'h03;
		@(posedge clock);
		ctrlBelowEntry <= 1'b1;
		@(posedge clock);
		lastStart = cyc;
		ctrlBelowEntry <= 1'b0;
		expQ.push_back(n);
		#1;
		`CHK(driverPulse, 1'b1)
		waitIdle();
		`CHK(pulseCount, 6'h03)
		for (i = 0; i < 4; i++) begin
			burst((i == 3 ? 3000 : 0) + int'(xs() % 200), 1'b0);
		end
		b = biasCode;
		`CHK(b < 8'hff, 1'b1)
		@(posedge clock);
		ctrlOptoBelowLow <= 1'b1;
		repeat (450) @(posedge clock);
		#1;
		`CHK(biasCode > b, 1'b1)
		burst(0, 1'b1);
		@(posedge clock);
		protActive <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		`CHK({supplyFastDischargeSink, burstMode}, 2'b10)
		`CHK(expQ.size() == 0, 1'b1)
		completeRun();
	end
endmodule
